// file: src/tcc_top.sv
// Four-channel capture/compare timer with 16-bit pulse accumulator.
// Assumes pin inputs synchronous to CLK and a classic Wishbone master.
module tcc_top
   import tcc_pkg::*;
(
   input wire logic CLK,
   input wire logic SRST,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [7:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   input wire logic [3:0] IOC_IN,
   output logic [3:0] IOC_OUT,
   output logic [3:0] IOC_OE_N,
   output logic [3:0] IRQ_CHAN,
   output logic IRQ_TOVF,
   output logic IRQ_ACC_OVF,
   output logic IRQ_ACC_IN
);

   ////////////////////////////////////////////////////////////////////////
   // Helpers.

   // Byte enables widened to a bit mask, used by every writable register.
   // Partial writes keep the untouched bytes of a register intact.
   function automatic logic [31:0] lane_mask(input logic [3:0] sel);
      lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
   endfunction

   // Compare action: 01 toggle, 10 clear, 11 set, 00 keeps the latch.
   // Mode 00 matters only at the pin, which then shows the port latch unless the channel is masked.
   function automatic logic cmp_act(input logic om, input logic ol,
                                    input logic cur);
      case ({om, ol})
         2'b01: cmp_act = ~cur;
         2'b10: cmp_act = 1'b0;
         2'b11: cmp_act = 1'b1;
         default: cmp_act = cur;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // State and derived events.

   tcc_state_t st_r; // Registered state.
   tcc_state_t st_nxt; // Next state.
   logic bus_take; // Access completes at this edge.
   logic wr; // Write completes at this edge.
   logic [31:0] wm; // Byte lane mask.
   logic [31:0] wmerge; // Write data with unused lanes cleared.
   logic timer_on; // Timer enabled.
   logic [6:0] pmask; // Prescaler tap mask.
   logic tick; // Timer counter clock.
   logic div64; // Divide-by-64 clock.
   logic [3:0] dir; // Direction selects.
   logic [3:0] rise; // Pin rising edges.
   logic [3:0] fall; // Pin falling edges.
   logic [3:0] cap_ev; // Capture events.
   logic [3:0] cmp_ev; // Compare matches.
   logic [3:0] frc; // Forced compares.
   logic [3:0] act; // Compare actions.
   logic [3:0] conn; // Pin driven by compare logic.
   logic ctr_rst; // Channel 7 resets the counter.
   logic tof_set; // Timer wraps.
   logic acc_on; // Accumulator enabled.
   logic gated; // Gated mode.
   logic edge_sel; // Accumulator edge select.
   logic gate_now; // Gate active now.
   logic gate_was; // Gate active last cycle.
   logic ev_edge; // Event mode edge.
   logic acc_inc; // Accumulator increments.
   logic ain_set; // Input flag event.
   logic aovf_set; // Accumulator overflow event.
   logic wr_acc; // Bus write to accumulator.
   logic [6:0] flg_clr; // Flag clears.

   assign bus_take = WB_CYC_I & WB_STB_I & st_r.ack;
   assign wr = bus_take & WB_WE_I;
   assign wm = lane_mask(WB_SEL_I);
   assign wmerge = WB_DAT_I & wm;
   assign timer_on = st_r.ctrl[CTL_TIMER_EN];
   // The prescaler is held at zero while the timer is off, so the first
   // tick after enabling comes one full divided period later.
   // Divider by 2**select taps the low prescaler bits.
   assign pmask = 7'((8'h01 << st_r.ctrl[CTL_PRESCALE +: 3]) - 8'h01);
   assign tick = timer_on & ((st_r.pre & pmask) == pmask);
   // The divide-by-64 clock exists only while the timer runs.
   assign div64 = timer_on & (st_r.pre[5:0] == DIV64_TAP);
   assign dir = st_r.cfg[CFG_DIR +: 4];
   // Edges are taken against last cycle's levels; pins are synchronous.
   assign rise = IOC_IN & ~st_r.pin_q;
   assign fall = ~IOC_IN & st_r.pin_q;
   // Force acts only on compare channels; the others ignore the bit.
   assign frc = (wr && WB_ADR_I == OFS_FORCE) ?
                (WB_DAT_I[3:0] & wm[3:0] & dir) : 4'h0;

   // Per-channel events. Each channel is either a capture input or a
   // compare output, never both, so the two event vectors are disjoint
   // and can share one flag bit per channel.
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_ch
         // An input channel captures on its selected edges.
         assign cap_ev[g] = ~dir[g] &
            ((st_r.cfg[CFG_EDGE + 2*g] & rise[g]) |
             (st_r.cfg[CFG_EDGE + 2*g + 1] & fall[g]));
         // An output channel matches when the counter equals it.
         assign cmp_ev[g] = dir[g] & tick &
            (st_r.cnt == st_r.ch[g]);
         assign act[g] = cmp_ev[g] | frc[g];
         // Masked channels stay on the compare path for the override.
         assign conn[g] = dir[g] & ((st_r.cfg[CFG_OM + g] |
            st_r.cfg[CFG_OL + g]) | st_r.cfg[CFG_MASK + g]);
      end
   endgenerate

   // Channel 7 may restart the counter. The reset replaces the increment
   // on the same tick, so the wrap flag cannot be raised by a reset.
   // This works whatever the accumulator does with the shared pin.
   assign ctr_rst = cmp_ev[CH7] & st_r.ctrl[CTL_CRST];
   assign tof_set = tick & ~ctr_rst & (st_r.cnt == ALL_ONES);

   // Accumulator events; the pin is shared with channel 7.
   // Software should disconnect channel 7 from the compare logic before
   // using the pin as an accumulator input; nothing here enforces it.
   assign acc_on = st_r.ctrl[CTL_ACC_EN];
   assign gated = st_r.ctrl[CTL_ACC_MODE];
   assign edge_sel = st_r.ctrl[CTL_ACC_EDGE];
   assign ev_edge = edge_sel ? rise[CH7] : fall[CH7];
   assign gate_now = edge_sel ? ~IOC_IN[CH7] : IOC_IN[CH7];
   assign gate_was = edge_sel ? ~st_r.pin_q[CH7] : st_r.pin_q[CH7];
   // Event counting needs no timer clock at all.
   assign acc_inc = acc_on & (gated ? (div64 & gate_now)
                                    : ev_edge);
   assign ain_set = acc_on & (gated ? (gate_was & ~gate_now)
                                    : ev_edge);
   assign aovf_set = acc_inc & (st_r.acc == ALL_ONES);
   assign wr_acc = wr && WB_ADR_I == OFS_ACCUM;
   assign flg_clr = (wr && WB_ADR_I == OFS_FLAGS) ? wmerge[6:0] : 7'h00;

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic.

   // One process computes every field of the next state.
   always_comb begin
      logic [31:0] rd;
      logic [1:0] idx;
      rd = 32'h0000_0000;
      idx = WB_ADR_I[3:2];
      st_nxt = st_r;
      // Edge detectors compare against the previous cycle's pin levels.
      st_nxt.pin_q = IOC_IN;
      // Prescaler runs only while the timer is enabled.
      st_nxt.pre = timer_on ? 7'(st_r.pre + 7'h01) : 7'h00;
      // Counter steps on the selected clock or is reset by channel 7.
      if (tick) begin
         st_nxt.cnt = ctr_rst ? 16'h0000
                              : 16'(st_r.cnt + 16'h0001);
      end
      // Captures take the counter value; bus writes cannot disturb them.
      for (int j = 0; j < 4; j++) begin
         // A capture overwrites the register whether or not it was read.
         if (cap_ev[j]) begin
            st_nxt.ch[j] = st_r.cnt;
         end
         // A forced compare takes the same pin action as a match.
         if (act[j]) begin
            st_nxt.oc[j] = cmp_act(st_r.cfg[CFG_OM + j],
               st_r.cfg[CFG_OL + j], st_r.oc[j]);
         end
      end
      // Channel 7 wins over the others on masked pins.
      // A forced channel 7 compare applies the override as well.
      if (act[CH7]) begin
         for (int j = 0; j < 4; j++) begin
            if (st_r.cfg[CFG_MASK + j]) begin
               st_nxt.oc[j] = st_r.cfg[CFG_DATA7 + j];
            end
         end
      end
      // Accumulator counts; a bus write below takes precedence.
      if (acc_inc) begin
         st_nxt.acc = 16'(st_r.acc + 16'h0001);
      end
      // Flags: a new event wins over a clear in the same cycle.
      // Forces never reach the channel flags; only captures and matches do.
      st_nxt.flags = (st_r.flags & ~flg_clr) |
         {ain_set, aovf_set, tof_set, cmp_ev | cap_ev};
      // Register writes at the acknowledging edge.
      // Writes follow the events, so a same-cycle write wins.
      if (wr) begin
         if (WB_ADR_I == OFS_CTRL) begin
            // Bits outside the writable mask always read zero.
            st_nxt.ctrl = ((st_r.ctrl & ~wm) | wmerge) & CTL_WMASK;
         end else if (WB_ADR_I == OFS_CFG) begin
            st_nxt.cfg = (st_r.cfg & ~wm) | wmerge;
         end else if (WB_ADR_I == OFS_PORT) begin
            // Only the latch changes; the pin may be owned by compare.
            st_nxt.port = (st_r.port & ~wm[3:0]) | wmerge[3:0];
         end else if (wr_acc) begin
            st_nxt.acc = (st_r.acc & ~wm[15:0]) | wmerge[15:0];
         end else if (WB_ADR_I[7:4] == OFS_CH_HI && dir[idx]) begin
            // Capture channels drop writes so no captured time is lost.
            st_nxt.ch[idx] = (st_r.ch[idx] & ~wm[15:0])
                           | wmerge[15:0];
         end
      end
      // Read multiplexer; unmapped addresses read zero.
      if (WB_ADR_I == OFS_CTRL) begin
         rd = st_r.ctrl;
      end else if (WB_ADR_I == OFS_CFG) begin
         rd = st_r.cfg;
      end else if (WB_ADR_I == OFS_FLAGS) begin
         rd = {25'h0000000, st_r.flags};
      end else if (WB_ADR_I == OFS_COUNT) begin
         // The counter is read only; writes to it are dropped.
         rd = {16'h0000, st_r.cnt};
      end else if (WB_ADR_I == OFS_ACCUM) begin
         rd = {16'h0000, st_r.acc};
      end else if (WB_ADR_I == OFS_PORT) begin
         rd = {28'h0000000, st_r.port};
      end else if (WB_ADR_I[7:4] == OFS_CH_HI) begin
         rd = {16'h0000, st_r.ch[idx]};
      end
      // Acknowledge one cycle after the request, then drop it.
      // The wait state lets read data come straight from a flip-flop.
      if (WB_CYC_I && WB_STB_I && !st_r.ack) begin
         st_nxt.ack = 1'b1;
         st_nxt.rdat = rd;
      end else begin
         st_nxt.ack = 1'b0;
      end
      // Nothing is latched from ports during reset.
      // The pin history clears to zero, so a pin idling high shows a rise
      // after reset; harmless, as every event source starts disabled.
      if (SRST) begin
         st_nxt = '0;
         st_nxt.ctrl = CTRL_RST;
         st_nxt.cfg = CFG_RST;
      end
   end

   // State register; reset is folded into the next state above.
   always_ff @(posedge CLK) begin
      st_r <= st_nxt;
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs.

   assign WB_DAT_O = st_r.rdat;
   assign WB_ACK_O = st_r.ack;
   // Compare channels drive their pins; free pins show the port latch.
   assign IOC_OUT = (conn & st_r.oc) | (~conn & st_r.port);
   // Direction alone sets the enable: a disconnected compare channel
   // still drives its pin, then with the port latch value.
   assign IOC_OE_N = ~dir;
   // Levels: each request stands while flag and enable are both set.
   // Software drops a request by clearing its flag or its enable.
   assign IRQ_CHAN = st_r.flags[FLG_CHAN +: 4]
                   & st_r.cfg[CFG_IE +: 4];
   assign IRQ_TOVF = st_r.flags[FLG_TOVF]
                   & st_r.ctrl[CTL_TOVF_IE];
   assign IRQ_ACC_OVF = st_r.flags[FLG_AOVF]
                      & st_r.ctrl[CTL_AOVF_IE];
   assign IRQ_ACC_IN = st_r.flags[FLG_AIN]
                     & st_r.ctrl[CTL_AIN_IE];

   ////////////////////////////////////////////////////////////////////////
   // Assertions and covers.

   default clocking cb @(posedge CLK); endclocking
   default disable iff (SRST);

   // Capture, compare and pin checks, on the channels the bench uses.
   cap_value_a: assert property (cap_ev[0]
      |=> st_r.ch[0] == $past(st_r.cnt))
      else $error("capture did not copy the counter");
   cap_flag_a: assert property (cap_ev[0] && st_r.cfg[CFG_IE] && !wr
      |=> st_r.flags[0] && IRQ_CHAN[0])
      else $error("capture flag or request missing");
   cmp_flag_a: assert property (cmp_ev[CH7] |=> st_r.flags[CH7])
      else $error("compare flag not set");
   disc_pin_a: assert property (dir[1] && !st_r.cfg[CFG_OM + 1] &&
      !st_r.cfg[CFG_OL + 1] && !st_r.cfg[CFG_MASK + 1]
      |-> IOC_OUT[1] == st_r.port[1])
      else $error("disconnected pin not on port latch");
   force_flag_a: assert property (frc[1] && !cmp_ev[1] &&
      !st_r.flags[1] |=> !st_r.flags[1])
      else $error("forced compare set the flag");
   ch7_over_a: assert property (cmp_ev[CH7] && st_r.cfg[CFG_MASK + 1]
      |=> st_r.oc[1] == $past(st_r.cfg[CFG_DATA7 + 1]))
      else $error("channel 7 override lost");
   cnt_reset_a: assert property (ctr_rst |=> st_r.cnt == 16'h0000)
      else $error("counter not reset by channel 7");
   // Accumulator checks; a bus write to the count is left out.
   acc_step_a: assert property (acc_on && !gated && ev_edge
      && !wr_acc |=> st_r.acc == 16'($past(st_r.acc) + 16'h0001))
      else $error("event edge not counted");
   acc_ovf_a: assert property (aovf_set && !wr_acc
      |=> st_r.acc == 16'h0000 && st_r.flags[FLG_AOVF])
      else $error("accumulator rollover not flagged");
   gate_off_a: assert property (acc_on && gated && !timer_on
      && !wr_acc |=> st_r.acc == $past(st_r.acc))
      else $error("gated mode counted without timer");
   gate_step_a: assert property (acc_on && gated && div64
      && gate_now && !wr_acc
      |=> st_r.acc == 16'($past(st_r.acc) + 16'h0001))
      else $error("gated pulse not counted");
   ain_flag_a: assert property (ain_set |=> st_r.flags[FLG_AIN])
      else $error("accumulator input flag not set");
   tovf_flag_a: assert property (tof_set |=> st_r.flags[FLG_TOVF])
      else $error("timer wrap not flagged");
   // Bus side and prescaler; a write in the window may change the rate.
   ic_write_a: assert property (wr && WB_ADR_I[7:4] == OFS_CH_HI &&
      !dir[WB_ADR_I[3:2]] && !(|cap_ev)
      |=> $stable(st_r.ch))
      else $error("capture register was written");
   w1c_keep_a: assert property (ain_set && flg_clr[FLG_AIN]
      |=> st_r.flags[FLG_AIN])
      else $error("set lost to a clear");
   tick_rate_a: assert property (timer_on && !wr && tick &&
      st_r.ctrl[CTL_PRESCALE +: 3] == 3'h1 ##1 !wr
      |-> !tick ##1 tick)
      else $error("divide by two cadence wrong");

   // Covers mark the main scenarios that the bench should reach.
   cap_seen_c: cover property (cap_ev[0] ##1 IRQ_CHAN[0]);
   cmp_seen_c: cover property (cmp_ev[CH7] && st_r.ctrl[CTL_CRST]);
   gate_seen_c: cover property (acc_on && gated && ain_set);
   ovf_seen_c: cover property (tof_set ##1 IRQ_TOVF);
   acc_seen_c: cover property (aovf_set ##1 IRQ_ACC_OVF);

endmodule

// file: src/tcc_pkg.sv
// Package for the four-channel capture/compare timer with accumulator.
// Assumes a classic Wishbone master with 32-bit data and byte addresses.
package tcc_pkg;
   // Register byte offsets.
   localparam logic [7:0] OFS_CTRL = 8'h00; // Global control.
   localparam logic [7:0] OFS_CFG = 8'h04; // Channel configuration.
   localparam logic [7:0] OFS_FLAGS = 8'h08; // Sticky flags, write one.
   localparam logic [7:0] OFS_FORCE = 8'h0c; // Force compare, reads 0.
   localparam logic [7:0] OFS_COUNT = 8'h10; // Timer counter, read only.
   localparam logic [7:0] OFS_ACCUM = 8'h14; // Accumulator count.
   localparam logic [7:0] OFS_PORT = 8'h18; // General-purpose latch.
   localparam logic [3:0] OFS_CH_HI = 4'h2; // Channels at 0x20..0x2c.
   // Control register fields.
   localparam int CTL_TIMER_EN = 0; // The timer enable bit.
   localparam int CTL_PRESCALE = 1; // Three-bit prescale select.
   localparam int CTL_CRST = 4; // Counter reset on channel 7.
   localparam int CTL_TOVF_IE = 5; // Timer overflow irq enable.
   localparam int CTL_ACC_EN = 6; // Accumulator enable.
   localparam int CTL_ACC_MODE = 7; // 1 gated, 0 event count.
   localparam int CTL_ACC_EDGE = 8; // Accumulator edge select.
   localparam int CTL_AOVF_IE = 9; // Accumulator overflow irq en.
   localparam int CTL_AIN_IE = 10; // Accumulator input irq enable.
   localparam logic [31:0] CTL_WMASK = 32'h0000_07ff; // Writable bits.
   // Configuration register fields, four bits per group except the eight edge bits, ch4 lowest.
   localparam int CFG_DIR = 0; // Direction select, 1 compare.
   localparam int CFG_IE = 4; // Channel irq enable.
   localparam int CFG_OM = 8; // Output mode.
   localparam int CFG_OL = 12; // Output level.
   localparam int CFG_MASK = 16; // Channel 7 override mask.
   localparam int CFG_DATA7 = 20; // Channel 7 override data.
   localparam int CFG_EDGE = 24; // Capture edges, 2 bits each.
   // Flag register fields.
   localparam int FLG_CHAN = 0; // Channel event flags.
   localparam int FLG_TOVF = 4; // Timer overflow flag.
   localparam int FLG_AOVF = 5; // Accumulator overflow flag.
   localparam int FLG_AIN = 6; // Accumulator input flag.
   // Reset values and fixed figures.
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] CFG_RST = 32'h0000_0000;
   localparam logic [15:0] ALL_ONES = 16'hffff;
   localparam logic [5:0] DIV64_TAP = 6'h3f; // Prescaler divide-by-64.
   localparam int CH7 = 3; // Index of channel 7.
   // Whole state of the block.
   typedef struct packed {
      logic ack; // Wishbone acknowledge.
      logic [31:0] rdat; // Read data.
      logic [31:0] ctrl; // Control register.
      logic [31:0] cfg; // Configuration register.
      logic [6:0] flags; // Sticky flags.
      logic [3:0] port; // General-purpose output latch.
      logic [3:0] oc; // Compare output latches.
      logic [6:0] pre; // Prescaler.
      logic [15:0] cnt; // Free-running timer counter.
      logic [15:0] acc; // Pulse accumulator.
      logic [3:0] pin_q; // Previous pin levels.
      logic [3:0][15:0] ch; // Channel capture/compare registers.
   } tcc_state_t;
endpackage

// file: test/tcc_pin_model.sv
// Model of the outside world at the four timer pins.
// Assumes the bench calls the drive task from one process at a time.
module tcc_pin_model
   import tcc_pkg::*;
(
   input wire logic clk,
   input wire logic [3:0] out_val,
   input wire logic [3:0] oe_n,
   output logic [3:0] pin
);
   ////////////////////////////////////////////////////////////////////
   logic [3:0] ext_r = 4'h0; // Levels the outside world applies.

   // A pin the timer drives shows the timer's value; a free pin shows
   // the outside level, so the two never fight on the wire.
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         pin[i] = oe_n[i] ? ext_r[i] : out_val[i];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Changes one pin just after an edge, then holds it for four clocks.
   // Pulses down to one clock would still reach the edge detectors.
   task automatic drive(input int ch, input logic lvl);
      @(posedge clk);
      ext_r[ch] <= lvl;
      repeat (4) @(posedge clk);
   endtask
endmodule

// file: test/tcc_top_test.sv
// Self-checking bench for the capture/compare timer and accumulator.
// Assumes the pin model beside it and a 40 MHz clock.
module tcc_top_test
   import tcc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   ////////////////////////////////////////////////////////////////////
   logic CLK = 1'b0; // Bus clock.
   logic SRST = 1'b1; // Held high for the first cycles.
   logic WB_CYC_I = 1'b0;
   logic WB_STB_I = 1'b0;
   logic WB_WE_I = 1'b0;
   logic [7:0] WB_ADR_I = 8'h00;
   logic [3:0] WB_SEL_I = 4'hf;
   logic [31:0] WB_DAT_I = 32'h0;
   logic [31:0] WB_DAT_O;
   logic WB_ACK_O;
   logic [3:0] IOC_IN, IOC_OUT, IOC_OE_N, IRQ_CHAN;
   logic IRQ_TOVF, IRQ_ACC_OVF, IRQ_ACC_IN;
   int n_errors = 0; // Mismatches seen.
   int compares = 0; // Comparisons made.

   always #12.5 CLK = ~CLK;

   tcc_top i_dut (.CLK(CLK), .SRST(SRST), .WB_CYC_I(WB_CYC_I),
      .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
      .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
      .WB_ACK_O(WB_ACK_O), .IOC_IN(IOC_IN), .IOC_OUT(IOC_OUT),
      .IOC_OE_N(IOC_OE_N), .IRQ_CHAN(IRQ_CHAN), .IRQ_TOVF(IRQ_TOVF),
      .IRQ_ACC_OVF(IRQ_ACC_OVF), .IRQ_ACC_IN(IRQ_ACC_IN));

   tcc_pin_model i_pins (.clk(CLK), .out_val(IOC_OUT), .oe_n(IOC_OE_N),
      .pin(IOC_IN));

   ////////////////////////////////////////////////////////////////////
   // One classic cycle; the request stands until ack is sampled high.
   task automatic wb(input logic we, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
      @(posedge CLK);
      WB_CYC_I <= 1'b1;
      WB_STB_I <= 1'b1;
      WB_WE_I <= we;
      WB_ADR_I <= a;
      WB_SEL_I <= 4'hf;
      WB_DAT_I <= d;
      // No cycle count is assumed; only the watchdog ends a hang.
      do begin
         @(posedge CLK);
      end while (WB_ACK_O !== 1'b1);
      q = WB_DAT_O;
      WB_CYC_I <= 1'b0;
      WB_STB_I <= 1'b0;
      WB_WE_I <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      wb(1'b0, a, 32'h0, q);
   endtask

   // Range compare; an unknown never counts as inside the range.
   task automatic chk(input logic [31:0] got, input logic [31:0] lo,
                      input logic [31:0] hi);
      compares++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, lo);
      end
   endtask

   // Polls the flags until the given bit shows, within a bound.
   task automatic wait_flag(input int b);
      logic [31:0] q;
      int n;
      n = 0;
      q = 32'h0;
      while (q[b] !== 1'b1 && n < 200) begin
         rd(OFS_FLAGS, q);
         n++;
      end
      // A flag that never shows counts as a mismatch.
      if (q[b] !== 1'b1) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, q, 32'h1 << b);
      end
   endtask

   task automatic note(input string s);
      $display("test %s done", s);
   endtask

   task automatic tally_and_finish();
      $display("compares %0d errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////
   // Cuts a hang short; the longest wait is one full counter wrap.
   initial begin
      repeat (95000) @(posedge CLK);
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, 1'b0, 1'b1);
      tally_and_finish();
   end

   initial begin
      logic [31:0] q, c1, c2;
      int k;
      repeat (5) @(posedge CLK);
      SRST <= 1'b0;
      rd(OFS_ACCUM, q);
      chk(q, 32'h0, 32'h0);
      rd(8'h3c, q);
      chk(q, 32'h0, 32'h0);
      // Capture on a rising edge of the first channel.
      wr(OFS_CTRL, 32'h1);
      wr(OFS_CFG, 32'h0100_0010);
      rd(OFS_COUNT, c1);
      i_pins.drive(0, 1'b1);
      rd({OFS_CH_HI, 4'h0}, q);
      rd(OFS_COUNT, c2);
      chk(q, c1, c2);
      rd(OFS_FLAGS, c1);
      chk(c1, 32'h1, 32'h1);
      chk({28'h0, IRQ_CHAN}, 32'h1, 32'h1);
      wr({OFS_CH_HI, 4'h0}, 32'h1234);
      rd({OFS_CH_HI, 4'h0}, c2);
      chk(c2, q, q);
      wr(OFS_FLAGS, 32'h1);
      @(negedge CLK);
      chk({28'h0, IRQ_CHAN}, 32'h0, 32'h0);
      i_pins.drive(0, 1'b0);
      note("capture");
      // Compare sets the second pin, then a forced compare in clear mode drives it low.
      wr(OFS_CFG, 32'h0000_2202);
      rd(OFS_COUNT, c1);
      wr({OFS_CH_HI, 4'h4}, {16'h0, c1[15:0] + 16'd60});
      wait_flag(1);
      rd(OFS_FLAGS, q);
      chk(q, 32'h2, 32'h2);
      chk({28'h0, IOC_OUT & ~IOC_OE_N}, 32'h2, 32'h2);
      wr(OFS_PORT, 32'h0);
      @(negedge CLK);
      chk({31'h0, IOC_OUT[1]}, 32'h1, 32'h1);
      wr(OFS_FLAGS, 32'h2);
      wr(OFS_CFG, 32'h0000_0202);
      wr(OFS_FORCE, 32'h2);
      @(negedge CLK);
      chk({31'h0, IOC_OUT[1]}, 32'h0, 32'h0);
      rd(OFS_FLAGS, q);
      chk(q, 32'h0, 32'h0);
      wr(OFS_PORT, 32'h2);
      wr(OFS_CFG, 32'h0000_0002);
      @(negedge CLK);
      chk({31'h0, IOC_OUT[1]}, 32'h1, 32'h1);
      note("compare");
      // Channel 7 match overrides the masked pin and clears the counter.
      wr(OFS_CTRL, 32'h11);
      wr(OFS_CFG, 32'h0002_220a);
      wr(OFS_FORCE, 32'h2);
      rd(OFS_COUNT, c1);
      wr({OFS_CH_HI, 4'hc}, {16'h0, c1[15:0] + 16'd80});
      wait_flag(3);
      rd(OFS_COUNT, q);
      chk(q, 32'h0, 32'h40);
      chk({31'h0, IOC_OUT[1]}, 32'h0, 32'h0);
      note("channel 7");
      // Every prescale setting over one fixed span.
      for (int n = 0; n < 8; n++) begin
         wr(OFS_CTRL, 32'h1 | 32'(n << 1));
         rd(OFS_COUNT, c1);
         repeat (1000) @(posedge CLK);
         rd(OFS_COUNT, c2);
         q = {16'h0, c2[15:0] - c1[15:0]};
         chk(q, 32'((1003 >> n) - 1), 32'((1003 >> n) + 1));
      end
      wr(OFS_FLAGS, 32'h7f);
      wr(OFS_CTRL, 32'h21);
      k = 0;
      while (IRQ_TOVF !== 1'b1 && k < 70000) begin
         @(negedge CLK);
         k++;
      end
      chk({31'h0, IRQ_TOVF}, 32'h1, 32'h1);
      rd(OFS_FLAGS, q);
      chk(q & 32'h10, 32'h10, 32'h10);
      note("prescale and overflow");
      // Event counting with the timer stopped, both edge selections.
      wr(OFS_CFG, 32'h0);
      wr(OFS_CTRL, 32'h740);
      wr(OFS_ACCUM, 32'hffff);
      wr(OFS_FLAGS, 32'h7f);
      i_pins.drive(3, 1'b1);
      rd(OFS_ACCUM, q);
      chk(q, 32'h0, 32'h0);
      rd(OFS_FLAGS, q);
      chk(q, 32'h60, 32'h60);
      chk({30'h0, IRQ_ACC_OVF, IRQ_ACC_IN}, 32'h3, 32'h3);
      wr(OFS_FLAGS, 32'h0);
      rd(OFS_FLAGS, q);
      chk(q, 32'h60, 32'h60);
      wr(OFS_FLAGS, 32'h60);
      rd(OFS_FLAGS, q);
      chk(q, 32'h0, 32'h0);
      wr(OFS_CTRL, 32'h640);
      i_pins.drive(3, 1'b0);
      i_pins.drive(3, 1'b1);
      rd(OFS_ACCUM, q);
      chk(q, 32'h1, 32'h1);
      note("event count");
      // Gated counting: none while the timer is off, then both levels.
      wr(OFS_CTRL, 32'h5c0);
      wr(OFS_ACCUM, 32'h0);
      i_pins.drive(3, 1'b0);
      repeat (300) @(posedge CLK);
      rd(OFS_ACCUM, q);
      chk(q, 32'h0, 32'h0);
      wr(OFS_CTRL, 32'h5c1);
      repeat (640) @(posedge CLK);
      wr(OFS_FLAGS, 32'h7f);
      i_pins.drive(3, 1'b1);
      rd(OFS_ACCUM, q);
      chk(q, 32'h9, 32'hb);
      rd(OFS_FLAGS, q);
      chk(q & 32'h40, 32'h40, 32'h40);
      wr(OFS_CTRL, 32'h4c1);
      wr(OFS_ACCUM, 32'h0);
      repeat (320) @(posedge CLK);
      i_pins.drive(3, 1'b0);
      rd(OFS_ACCUM, q);
      chk(q, 32'h4, 32'h6);
      note("gated");
      tally_and_finish();
   end
endmodule
